// >>> logic/ioe_output_expander.sv
// serial-bus controlled eight-line push-pull output expander
`timescale 1ns/1ps
`default_nettype none
module ioe_output_expander (
  input  wire logic               clk,         // system clock, 125 MHz
  input  wire logic               sys_rst,     // async reset, active high
  input  wire logic               scl,         // serial clock from master
  input  wire logic               sdaIn,       // serial data line level
  output wire logic               sdaOut,      // serial data drive value
  output wire logic               sdaOe,       // serial data pull-low enable
  input  wire ioe_pkg::ioe_byte_t pinLevel,    // sensed output pin levels
  output wire ioe_pkg::ioe_byte_t outLine,     // output line levels
  output wire ioe_pkg::ioe_byte_t highSideOn,  // high-side driver enables
  output wire ioe_pkg::ioe_byte_t lowSideOn    // low-side driver enables
);
  import ioe_pkg::*;

  // address decode shared by ack choice and checks
  function automatic logic addrHit(input ioe_byte_t word, input logic [6:0] addr);
    addrHit = (word[MSB_POS:RW_POS+1] == addr);
  endfunction : addrHit

  ioe_link_if linkIf ();

  ioe_link_shift uShift (
    .scl     (scl),
    .sys_rst (sys_rst),
    .sdaIn   (sdaIn),
    .link    (linkIf.link)
  );

  // two-stage synchronisers and history
  logic      sclM_q, sclS_q, sclP_q;
  logic      sdaM_q, sdaS_q, sdaP_q;
  ioe_byte_t pinM_q, pinS_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclM_q <= 1'b1;
      sclS_q <= 1'b1;
      sclP_q <= 1'b1;
      sdaM_q <= 1'b1;
      sdaS_q <= 1'b1;
      sdaP_q <= 1'b1;
      pinM_q <= LATCH_RESET;
      pinS_q <= LATCH_RESET;
    end else begin
      sclM_q <= scl;
      sclS_q <= sclM_q;
      sclP_q <= sclS_q;
      sdaM_q <= sdaIn;
      sdaS_q <= sdaM_q;
      sdaP_q <= sdaS_q;
      pinM_q <= pinLevel;
      pinS_q <= pinM_q;
    end
  end

  // bus events from synchronised levels
  wire sclRise  = sclS_q & ~sclP_q;
  wire sclFall  = ~sclS_q & sclP_q;
  wire startEv  = sclS_q & sclP_q & sdaP_q & ~sdaS_q;
  wire stopEv   = sclS_q & sclP_q & ~sdaP_q & sdaS_q;
  wire rxWord_w = 1'b0;

  // engine state
  ioe_phase_e phase_q, phase_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic       ackSlot_q, ackSlot_d;
  logic       ackGo_q, ackGo_d;
  logic       sdaOe_q, sdaOe_d;
  logic       dataAck_q, dataAck_d;
  ioe_byte_t  rxByte_q, rxByte_d;
  ioe_byte_t  txByte_q, txByte_d;
  ioe_byte_t  pinSnap_q, pinSnap_d;
  ioe_byte_t  outLatch_q, outLatch_d;

  // decode of the completed byte
  wire       countOn  = (phase_q == PH_ADDR) || (phase_q == PH_WRITE) ||
                        (phase_q == PH_READ) || (phase_q == PH_GCALL) ||
                        (phase_q == PH_GCDONE);
  wire       byteDone = sclFall & ~ackSlot_q & (bitCnt_q == BYTE_BITS);
  wire       ackEnd   = sclFall & ackSlot_q;
  ioe_byte_t word;
  assign word = linkIf.shiftWord;
  wire       ownHit   = addrHit(word, OWN_ADDR);
  wire       gcHit    = addrHit(word, GCALL_ADDR) & ~word[RW_POS];
  wire       idHit    = addrHit(word, ID_ADDR);
  wire       gcReset  = stopEv & (phase_q == PH_GCDONE);

  // next-state of the bus engine
  always_comb begin
    phase_d    = phase_q;
    bitCnt_d   = bitCnt_q;
    ackSlot_d  = ackSlot_q;
    ackGo_d    = ackGo_q;
    sdaOe_d    = sdaOe_q;
    dataAck_d  = dataAck_q;
    rxByte_d   = rxByte_q;
    txByte_d   = txByte_q;
    pinSnap_d  = pinSnap_q;
    outLatch_d = outLatch_q;
    if (startEv) begin
      // [R14] partial byte dropped
      phase_d   = PH_ADDR;
      bitCnt_d  = BIT_ZERO;
      ackSlot_d = 1'b0;
      sdaOe_d   = 1'b0;
    end else if (stopEv) begin
      // [R12] reset after 06h stop
      if (phase_q == PH_GCDONE) begin
        outLatch_d = LATCH_RESET;
      end
      phase_d   = PH_IDLE;
      bitCnt_d  = BIT_ZERO;
      ackSlot_d = 1'b0;
      sdaOe_d   = 1'b0;
    end else if (sclRise) begin
      if (!ackSlot_q && countOn) begin
        bitCnt_d = bitCnt_q + BIT_ONE;
      end
      // [R7] resample every acknowledge
      if (ackSlot_q && phase_q == PH_READ) begin
        pinSnap_d = pinS_q;
        if (!ackGo_q && sdaS_q) begin
          phase_d = PH_SKIP;
        end
      end
    end else if (byteDone) begin
      ackSlot_d = 1'b1;
      ackGo_d   = 1'b0;
      // [R4] only data bytes may commit
      dataAck_d = (phase_q == PH_WRITE);
      case (phase_q)
        PH_ADDR: begin
          // [R11] own address decode
          if (ownHit) begin
            // [R3] [R6] direction bit picks mode
            phase_d = word[RW_POS] ? PH_READ : PH_WRITE;
            ackGo_d = 1'b1;
          end else if (gcHit) begin
            phase_d = PH_GCALL;
            ackGo_d = 1'b1;
          end else if (idHit) begin
            phase_d = PH_SKIP;
            ackGo_d = 1'b1;
          end else begin
            // [R13] foreign address ignored
            phase_d = PH_SKIP;
          end
        end
        PH_WRITE: begin
          rxByte_d = word;
          ackGo_d  = 1'b1;
        end
        PH_GCALL: begin
          // [R12] only 06h acknowledged
          if (word == SWRST_BYTE) begin
            phase_d = PH_GCDONE;
            ackGo_d = 1'b1;
          end else begin
            phase_d = PH_SKIP;
          end
        end
        PH_GCDONE: begin
          phase_d = PH_SKIP;
        end
        PH_READ: begin
          ackGo_d = 1'b0;
        end
        default: begin
          phase_d = PH_SKIP;
        end
      endcase
      sdaOe_d = ackGo_d;
    end else if (ackEnd) begin
      ackSlot_d = 1'b0;
      bitCnt_d  = BIT_ZERO;
      sdaOe_d   = 1'b0;
      // [R4] [R5] commit after acknowledge
      if (phase_q == PH_WRITE && ackGo_q && dataAck_q) begin
        outLatch_d = rxByte_q;
      end
      // [R8] pin state, low bits pull line
      if (phase_q == PH_READ) begin
        txByte_d = pinSnap_q;
        sdaOe_d  = ~pinSnap_q[MSB_POS];
      end
    end else if (sclFall && phase_q == PH_READ && bitCnt_q != BIT_ZERO) begin
      txByte_d = {txByte_q[MSB_POS-1:0], 1'b0};
      sdaOe_d  = ~txByte_q[MSB_POS-1];
    end
  end

  // engine registers, outputs high from reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // [R10] [R1] power-up values
      phase_q    <= PH_IDLE;
      bitCnt_q   <= BIT_ZERO;
      ackSlot_q  <= 1'b0;
      ackGo_q    <= 1'b0;
      sdaOe_q    <= 1'b0;
      dataAck_q  <= 1'b0;
      rxByte_q   <= LATCH_RESET;
      txByte_q   <= LATCH_RESET;
      pinSnap_q  <= LATCH_RESET;
      outLatch_q <= LATCH_RESET;
    end else begin
      phase_q    <= phase_d;
      bitCnt_q   <= bitCnt_d;
      ackSlot_q  <= ackSlot_d;
      ackGo_q    <= ackGo_d;
      sdaOe_q    <= sdaOe_d;
      dataAck_q  <= dataAck_d;
      rxByte_q   <= rxByte_d;
      txByte_q   <= txByte_d;
      pinSnap_q  <= pinSnap_d;
      outLatch_q <= outLatch_d;
    end
  end

  // open-drain data line, only ever pulled low
  assign sdaOut = rxWord_w;
  assign sdaOe  = sdaOe_q;
  assign outLine = outLatch_q;

  // [R2] [R9] one driver pair per line
  genvar gi;
  generate
    for (gi = 0; gi < LINE_COUNT; gi++) begin : gLine
      assign highSideOn[gi] = outLatch_q[gi];
      assign lowSideOn[gi]  = ~outLatch_q[gi];
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence wrCommit;
    ackEnd && phase_q == PH_WRITE && ackGo_q && dataAck_q;
  endsequence

  sequence rdLoad;
    ackEnd && phase_q == PH_READ;
  endsequence

  sequence ownAddr;
    byteDone && phase_q == PH_ADDR && ownHit;
  endsequence

  // lines high right after reset release
  reset_high_a: assert property ($past(sys_rst) |-> outLine == LATCH_RESET) // [R1]
    else $error("lines not high after reset");

  // driver pair follows latch bit
  driver_pair_a: assert property (highSideOn == outLine && lowSideOn == ~outLine) // [R2]
    else $error("driver enables disagree with latch");

  // latch moves only on commit or soft reset
  latch_update_a: assert property ($changed(outLatch_q) |-> // [R4]
      $past(ackEnd && phase_q == PH_WRITE && ackGo_q && dataAck_q) || $past(gcReset))
    else $error("latch changed outside acknowledge end");

  // committed byte equals received byte
  write_commit_a: assert property (wrCommit |=> outLatch_q == $past(rxByte_q)) // [R5]
    else $error("write byte not committed");

  // own address acknowledged next cycle
  own_ack_a: assert property (ownAddr |=> sdaOe_q ##0 ackSlot_q) // [R11]
    else $error("own address not acknowledged");

  // foreign address leaves data released
  foreign_nack_a: assert property (byteDone && phase_q == PH_ADDR && !ownHit && // [R13]
      !gcHit && !idHit |=> !sdaOe_q [*2])
    else $error("foreign address acknowledged");

  // pins sampled at acknowledge rise
  pin_sample_a: assert property (sclRise && ackSlot_q && phase_q == PH_READ |=> // [R7]
      pinSnap_q == $past(pinS_q))
    else $error("pins not resampled at acknowledge");

  // first read bit pulls low only for zero
  read_msb_a: assert property (rdLoad |=> sdaOe_q == ~$past(pinSnap_q[MSB_POS])) // [R8]
    else $error("read bit polarity wrong");

  // soft reset restores high outputs
  gc_reset_a: assert property (gcReset |=> outLine == LATCH_RESET ##0 phase_q == PH_IDLE) // [R12]
    else $error("general call reset not applied");

  // start or stop mid-write keeps latch
  partial_drop_a: assert property ((startEv || stopEv) && phase_q == PH_WRITE |=> // [R14]
      $stable(outLatch_q))
    else $error("partial byte reached latch");

  // address acknowledge never moves the latch
  addr_ack_hold_a: assert property (ackEnd && !dataAck_q |=> $stable(outLatch_q)) // [R4]
    else $error("latch changed at address acknowledge");

  // direction bit one enters read mode
  read_select_a: assert property (ownAddr ##0 word[RW_POS] |=> phase_q == PH_READ) // [R6]
    else $error("read address did not select read mode");

endmodule : ioe_output_expander
`default_nettype wire

// >>> logic/ioe_pkg.sv
// constants, phase codes and contract list for the serial output expander
//
// Contract
// [R1] all eight lines high after any reset
// [R2] latch bit 1 drives high, 0 drives low
// [R3] address with direction 0 selects a write
// [R4] lines update only after byte acknowledged
// [R5] unlimited write bytes, each replaces latch
// [R6] address with direction 1 returns pin levels
// [R7] unlimited reads, pins resampled every acknowledge
// [R8] read bit 1 means high, 0 low
// [R9] eight independent output only lines
// [R10] held in reset, then outputs high
// [R11] answers fixed seven-bit address 4Ah
// [R12] general call 06h then stop resets
// [R13] foreign address left unacknowledged
// [R14] start or stop mid-byte drops partial byte
package ioe_pkg;

  localparam int          LINE_COUNT  = 8;
  localparam logic [6:0]  OWN_ADDR    = 7'h4A;
  localparam logic [6:0]  GCALL_ADDR  = 7'h00;
  localparam logic [6:0]  ID_ADDR     = 7'h7C;
  localparam logic [7:0]  SWRST_BYTE  = 8'h06;
  localparam logic [7:0]  LATCH_RESET = 8'hFF;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [3:0]  BIT_ZERO    = 4'h0;
  localparam logic [3:0]  BIT_ONE     = 4'h1;
  localparam int          RW_POS      = 0;
  localparam int          MSB_POS     = 7;

  // transaction phase of the bus engine
  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_ADDR   = 3'b001,
    PH_WRITE  = 3'b010,
    PH_READ   = 3'b011,
    PH_GCALL  = 3'b100,
    PH_GCDONE = 3'b101,
    PH_SKIP   = 3'b110
  } ioe_phase_e;

  typedef logic [LINE_COUNT-1:0] ioe_byte_t;

endpackage : ioe_pkg

// >>> logic/ioe_link_if.sv
// carrier for the byte shifted in on the serial clock
`timescale 1ns/1ps
`default_nettype none
interface ioe_link_if;
  import ioe_pkg::*;

  ioe_byte_t shiftWord;   // last eight data bits seen on scl rise

  modport link (output shiftWord);
  modport core (input  shiftWord);
endinterface : ioe_link_if
`default_nettype wire

// >>> logic/ioe_link_shift.sv
// serial-clock domain receive shifter
`timescale 1ns/1ps
`default_nettype none
module ioe_link_shift (
  input  wire logic   scl,       // serial clock, link domain
  input  wire logic   sys_rst,   // async reset, active high
  input  wire logic   sdaIn,     // serial data level
  ioe_link_if.link    link       // shifted word to core
);
  import ioe_pkg::*;

  ioe_byte_t shift_q;

  // shift data in on every rising serial clock
  always_ff @(posedge scl or posedge sys_rst) begin
    if (sys_rst) begin
      shift_q <= '0;
    end else begin
      shift_q <= {shift_q[MSB_POS-1:0], sdaIn};
    end
  end

  // word stays still until the next scl rise
  assign link.shiftWord = shift_q;

endmodule : ioe_link_shift
`default_nettype wire

// >>> tb/ioe_bus_master.sv
// serial bus master model that drives the expander from the far side
`timescale 1ns/1ps
`default_nettype none
module ioe_bus_master (
  output var logic scl,     // serial clock, parked high between frames
  output var logic sdaLow,  // pulls the data line low
  input  wire logic sdaLine // resolved data line level
);
  // idle bus at time zero
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end

  // start or repeated start, leaves clock low
  task automatic start_cond();
    sdaLow <= 1'b0;
    #36 scl <= 1'b1;
    #36 sdaLow <= 1'b1;
    #36 scl <= 1'b0;
    #4;
  endtask : start_cond

  task automatic stop_cond();
    sdaLow <= 1'b1;
    #36 scl <= 1'b1;
    #36 sdaLow <= 1'b0;
    #40;
  endtask : stop_cond

  // one bit slot, data set up well before the rise, sampled mid-high
  task automatic bit_cell(input logic b, output logic r);
    sdaLow <= ~b;
    #36 scl <= 1'b1;
    #20 r = sdaLine;
    #20 scl <= 1'b0;
    #4;
  endtask : bit_cell

  // eight bits msb first, direction bit last
  task automatic shift_byte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      bit_cell(d[i], q[i]);
    end
  endtask : shift_byte
endmodule : ioe_bus_master
`default_nettype wire

// >>> tb/ioe_output_expander_tb_top.sv
// testbench for the serial output expander
`timescale 1ns/1ps
`default_nettype none
module ioe_output_expander_tb_top;
  import ioe_pkg::*;
  logic      clk;
  logic      sys_rst;
  logic      sdaOut;
  logic      sdaOe;
  logic      scl;
  logic      sdaLow;
  logic      sdaLine;
  ioe_byte_t pinFlip;
  ioe_byte_t outLine;
  ioe_byte_t highSideOn;
  ioe_byte_t lowSideOn;
  logic      ack;
  logic      nul;
  ioe_byte_t pre;
  ioe_byte_t q;
  int        error_cnt;
  int        check_count;

  // open-drain data line with pull-up
  assign sdaLine = ~sdaLow & (sdaOe ? sdaOut : 1'b1);

  ioe_output_expander u_ioe_output_expander (
    .clk(clk), .sys_rst(sys_rst), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .pinLevel(outLine ^ pinFlip), .outLine(outLine),
    .highSideOn(highSideOn), .lowSideOn(lowSideOn));

  ioe_bus_master u_ioe_bus_master (.scl(scl), .sdaLow(sdaLow), .sdaLine(sdaLine));

  // system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // compare and count
  task automatic check(input ioe_byte_t got, input ioe_byte_t exp);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : check

  // start plus address byte, ack left in ack
  task automatic addr(input ioe_byte_t a);
    u_ioe_bus_master.start_cond();
    u_ioe_bus_master.shift_byte(a, q);
    u_ioe_bus_master.bit_cell(1'b1, ack);
  endtask : addr

  // data byte, latch seen before its ack kept in pre
  task automatic wdata(input ioe_byte_t d);
    u_ioe_bus_master.shift_byte(d, q);
    pre = outLine;
    u_ioe_bus_master.bit_cell(1'b1, ack);
    repeat (5) @(posedge clk);
  endtask : wdata

  // verdict and end of run
  task automatic wrap_up();
    $display("errors %0d, checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // hang guard, whole run is under twenty microseconds
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end

  // main sequence
  initial begin
    error_cnt   = 0;
    check_count = 0;
    sys_rst     = 1'b1;
    pinFlip     = 8'h00;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check(outLine, 8'hFF);
    check(lowSideOn, 8'h00);
    // write two bytes in one transaction
    addr(8'h94);
    check({7'h00, ack}, 8'h00);
    wdata(8'hA5);
    check({7'h00, ack}, 8'h00);
    check(pre, 8'hFF);
    check(outLine, 8'hA5);
    wdata(8'h3C);
    check(outLine, 8'h3C);
    check(highSideOn, 8'h3C);
    check(lowSideOn, 8'hC3);
    u_ioe_bus_master.stop_cond();
    // read two bytes, the first with two pins (bits 7 and 0) disagreeing with the latch
    @(posedge clk);
    pinFlip <= 8'h81;
    addr(8'h95);
    check({7'h00, ack}, 8'h00);
    u_ioe_bus_master.shift_byte(8'hFF, q);
    check(q, 8'hBD);
    @(posedge clk);
    pinFlip <= 8'h00;
    repeat (4) @(posedge clk);
    u_ioe_bus_master.bit_cell(1'b0, nul);
    u_ioe_bus_master.shift_byte(8'hFF, q);
    check(q, 8'h3C);
    u_ioe_bus_master.bit_cell(1'b1, nul);
    u_ioe_bus_master.stop_cond();
    // foreign address
    addr(8'hA4);
    check({7'h00, ack}, 8'h01);
    u_ioe_bus_master.stop_cond();
    // stop in mid byte
    addr(8'h94);
    for (int i = 0; i < 4; i++) begin
      u_ioe_bus_master.bit_cell(1'b0, nul);
    end
    u_ioe_bus_master.stop_cond();
    repeat (5) @(posedge clk);
    check(outLine, 8'h3C);
    // general call read and wrong byte
    addr(8'h01);
    check({7'h00, ack}, 8'h01);
    u_ioe_bus_master.stop_cond();
    addr(8'h00);
    check({7'h00, ack}, 8'h00);
    wdata(8'h07);
    check({7'h00, ack}, 8'h01);
    u_ioe_bus_master.stop_cond();
    // reset byte then repeated start
    addr(8'h00);
    wdata(8'h06);
    check({7'h00, ack}, 8'h00);
    u_ioe_bus_master.start_cond();
    u_ioe_bus_master.stop_cond();
    repeat (5) @(posedge clk);
    check(outLine, 8'h3C);
    // reset byte then stop
    addr(8'h00);
    wdata(8'h06);
    u_ioe_bus_master.stop_cond();
    repeat (5) @(posedge clk);
    check(outLine, 8'hFF);
    check(lowSideOn, 8'h00);
    // address alone commits nothing
    addr(8'h94);
    u_ioe_bus_master.stop_cond();
    repeat (5) @(posedge clk);
    check(outLine, 8'hFF);
    // identification address acknowledged, then ignored
    addr(8'hF8);
    check({7'h00, ack}, 8'h00);
    u_ioe_bus_master.stop_cond();
    // reset in mid-run with a written value in the latch
    addr(8'h94);
    wdata(8'h5A);
    u_ioe_bus_master.stop_cond();
    check(outLine, 8'h5A);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    check(outLine, 8'hFF);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check(highSideOn, 8'hFF);
    wrap_up();
  end
endmodule : ioe_output_expander_tb_top
`default_nettype wire
